// ### ascii_number_parser_pkg.sv
// Constants shared by the ASCII number parser and its helpers
package ascii_number_parser_pkg;

    // ****************************************************************
    // Character codes
    // ****************************************************************
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_ONE = 8'h31;
    localparam logic [7:0] CHAR_NINE = 8'h39;
    localparam logic [7:0] CHAR_UPPER_A = 8'h41;
    localparam logic [7:0] CHAR_UPPER_F = 8'h46;
    localparam logic [7:0] CHAR_LOWER_A = 8'h61;
    localparam logic [7:0] CHAR_LOWER_F = 8'h66;
    localparam logic [7:0] CHAR_MINUS = 8'h2d;
    localparam logic [7:0] CHAR_DOLLAR = 8'h24;
    localparam logic [7:0] CHAR_PERCENT = 8'h25;
    localparam logic [3:0] HEX_LETTER_BASE = 4'ha;

    // ****************************************************************
    // Sizes and limits
    // ****************************************************************
    localparam int RESULT_WIDTH = 16;
    localparam int SEQ_MAX = 6;
    localparam int SEQ_COUNT_WIDTH = 3;
    localparam int DIGIT_COUNT_WIDTH = 5;
    localparam logic [4:0] DEC_LIMIT_MAX = 5'h05;
    localparam logic [4:0] HEX_LIMIT_MAX = 5'h04;
    localparam logic [4:0] BIN_LIMIT_MAX = 5'h10;

    // ****************************************************************
    // Radixes and parser states
    // ****************************************************************
    typedef enum logic [1:0] {
        RADIX_TWO = 2'b00,
        RADIX_TEN = 2'b01,
        RADIX_SIXTEEN = 2'b10,
        RADIX_GENERIC = 2'b11
    } radix_sel_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEQ = 3'b001,
        ST_SCAN = 3'b010,
        ST_MINUS = 3'b011,
        ST_PREFIX = 3'b100,
        ST_DIGITS = 3'b101
    } parse_state_t;

endpackage : ascii_number_parser_pkg

// ### digit_classifier.sv
// Classifies one byte as a digit of a given radix
`timescale 1ns/10ps
module digit_classifier (
    input wire logic [7:0] charCode,
    input wire logic [1:0] radix,
    output logic isDigit,
    output logic [3:0] digitValue
);
    wire isDec = charCode >= ascii_number_parser_pkg::CHAR_ZERO
        && charCode <= ascii_number_parser_pkg::CHAR_NINE;
    wire isUpper = charCode >= ascii_number_parser_pkg::CHAR_UPPER_A
        && charCode <= ascii_number_parser_pkg::CHAR_UPPER_F;
    // Lower case letters mean the same as upper case in hex
    wire isLower = charCode >= ascii_number_parser_pkg::CHAR_LOWER_A
        && charCode <= ascii_number_parser_pkg::CHAR_LOWER_F;
    wire signed_prefixed_radix_two_format = charCode == ascii_number_parser_pkg::CHAR_ZERO
        || charCode == ascii_number_parser_pkg::CHAR_ONE;
    wire [7:0] decVal = charCode - ascii_number_parser_pkg::CHAR_ZERO;
    wire [7:0] upVal = charCode - ascii_number_parser_pkg::CHAR_UPPER_A;
    wire [7:0] loVal = charCode - ascii_number_parser_pkg::CHAR_LOWER_A;
    wire signed_prefixed_radix_sixteen_format = isDec || isUpper || isLower;

    assign isDigit = (radix == ascii_number_parser_pkg::RADIX_TWO) ? signed_prefixed_radix_two_format
        : (radix == ascii_number_parser_pkg::RADIX_SIXTEEN) ? signed_prefixed_radix_sixteen_format
        : isDec;
    assign digitValue = isDec ? decVal[3:0]
        : isUpper ? upVal[3:0] + ascii_number_parser_pkg::HEX_LETTER_BASE
        : loVal[3:0] + ascii_number_parser_pkg::HEX_LETTER_BASE;
endmodule : digit_classifier

// ### sequence_matcher.sv
// Waits for a fixed byte pattern of up to six bytes
`timescale 1ns/10ps
module sequence_matcher #(
    parameter int SEQ_MAX = ascii_number_parser_pkg::SEQ_MAX
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic start,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    input wire logic [8*SEQ_MAX-1:0] seqPattern,
    input wire logic [2:0] seqLength,
    output logic matched
);
    logic [2:0] matchCount;
    wire [7:0] expected = seqPattern[8*matchCount +: 8];
    wire [7:0] firstByte = seqPattern[7:0];
    // Exact code compare, so case differences never match
    wire hit = byteData == expected;
    wire restartHit = byteData == firstByte;
    wire [2:0] next_matchCount = hit ? matchCount + 3'h1
        : (restartHit ? 3'h1 : 3'h0);
    wire full = matchCount == seqLength;
    // Report the match on the byte that completes it, so that a digit
    // sent straight after the pattern is not lost
    assign matched = full || (byteValid && next_matchCount == seqLength);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            matchCount <= 3'h0;
        end else if (clkEn) begin
            if (start) begin
                matchCount <= 3'h0;
            end else if (byteValid && !full) begin
                matchCount <= next_matchCount;
            end
        end
    end
endmodule : sequence_matcher

// ### ascii_number_parser.sv
// ASCII text to binary number parser, top level
`timescale 1ns/10ps

// Functional notes
// - Non-numeric bytes discarded while searching, forever
// - Digits end only on terminator or limit
// - Terminator stores value, pulses done, releases caller
// - Result is 16 bits, wraps silently
// - Pattern bytes must arrive consecutively first
// - Pattern holds at most six bytes
// - Pattern compare exact, case sensitive
// - Accepted digits follow selected radix
// - Digits accumulate until terminator or count
// - Limits 1-5 decimal, 1-4 hex, 1-16 binary
// - Minus counts only if digit follows
// - Lower-case hex letters equal upper case
// - Prefixed formats ignore all but a signed minus until prefix
// - Prefix honoured only if digit follows
// - Signed prefixed minus precedes the prefix
// - Generic: plain digits decimal, others prefixed
// - Signed generic result is two's complement
// - Byte destination keeps low 8 bits
module ascii_number_parser #(
    parameter int SEQ_MAX = ascii_number_parser_pkg::SEQ_MAX
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic start,
    input wire logic [1:0] radixSel,
    input wire logic signedFormat,
    input wire logic prefixedFormat,
    input wire logic [4:0] digitLimit,
    input wire logic byteWide,
    input wire logic [2:0] seqLength,
    input wire logic [8*SEQ_MAX-1:0] seqPattern,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    output logic busy,
    output logic done,
    output logic [15:0] result
);
    // ****************************************************************
    // State
    // ****************************************************************
    ascii_number_parser_pkg::parse_state_t state;
    ascii_number_parser_pkg::parse_state_t next_state;
    logic [15:0] acc;
    logic [4:0] digitCount;
    logic negative;
    logic [1:0] activeRadix;
    logic [1:0] cfgRadix;
    logic cfgSigned;
    logic cfgPrefixed;
    logic [4:0] cfgLimit;
    logic cfgByte;
    logic [2:0] cfgSeqLength;

    // ****************************************************************
    // Byte decode
    // ****************************************************************
    wire seqMatched;
    wire isDigit;
    wire [3:0] digitValue;
    wire isMinus = byteData == ascii_number_parser_pkg::CHAR_MINUS;
    wire isDollar = byteData == ascii_number_parser_pkg::CHAR_DOLLAR;
    wire isPercent = byteData == ascii_number_parser_pkg::CHAR_PERCENT;
    wire isGeneric = cfgRadix == ascii_number_parser_pkg::RADIX_GENERIC;
    wire [1:0] plainRadix = isGeneric
        ? ascii_number_parser_pkg::RADIX_TEN : cfgRadix;
    // Prefix that matches the configured radix; generic takes either
    wire hexPrefixOk = isDollar && (isGeneric
        || cfgRadix == ascii_number_parser_pkg::RADIX_SIXTEEN);
    wire binPrefixOk = isPercent && (isGeneric
        || cfgRadix == ascii_number_parser_pkg::RADIX_TWO);
    wire prefixOk = hexPrefixOk || binPrefixOk;
    wire [1:0] prefixRadix = hexPrefixOk
        ? ascii_number_parser_pkg::RADIX_SIXTEEN
        : ascii_number_parser_pkg::RADIX_TWO;
    wire needPrefix = cfgPrefixed || isGeneric;
    wire [1:0] classRadix = (state == ascii_number_parser_pkg::ST_DIGITS
        || state == ascii_number_parser_pkg::ST_PREFIX)
        ? activeRadix : plainRadix;

    digit_classifier u_digit_classifier (
        .charCode(byteData),
        .radix(classRadix),
        .isDigit(isDigit),
        .digitValue(digitValue)
    );

    sequence_matcher #(
        .SEQ_MAX(SEQ_MAX)
    ) u_sequence_matcher (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .start(start),
        .byteValid(byteValid
            && state == ascii_number_parser_pkg::ST_SEQ),
        .byteData(byteData),
        .seqPattern(seqPattern),
        .seqLength(cfgSeqLength),
        .matched(seqMatched)
    );

    // ****************************************************************
    // Arithmetic
    // ****************************************************************
    wire [15:0] shiftTwo = {acc[14:0], 1'b0};
    wire [15:0] shiftSixteen = {acc[11:0], 4'h0};
    wire [15:0] timesTen = {acc[12:0], 3'h0} + {acc[14:0], 1'b0};
    wire [15:0] scaled = (activeRadix == ascii_number_parser_pkg::RADIX_TWO)
        ? shiftTwo
        : (activeRadix == ascii_number_parser_pkg::RADIX_SIXTEEN)
        ? shiftSixteen : timesTen;
    // Plain 16-bit sum drops the carry, so large input wraps
    wire [15:0] next_acc = scaled + {12'h000, digitValue};
    wire [15:0] firstAcc = {12'h000, digitValue};
    // Clamp the limit to the legal range of the radix
    wire [4:0] radixLimitMax =
        (activeRadix == ascii_number_parser_pkg::RADIX_TWO)
        ? ascii_number_parser_pkg::BIN_LIMIT_MAX
        : (activeRadix == ascii_number_parser_pkg::RADIX_SIXTEEN)
        ? ascii_number_parser_pkg::HEX_LIMIT_MAX
        : ascii_number_parser_pkg::DEC_LIMIT_MAX;
    wire [4:0] effLimit = (cfgLimit > radixLimitMax)
        ? radixLimitMax : cfgLimit;
    wire limitOn = cfgLimit != 5'h00;
    wire [15:0] negAcc = 16'h0000 - acc;
    wire [15:0] negNext = 16'h0000 - next_acc;
    wire [15:0] finalTerm = negative ? negAcc : acc;
    wire [15:0] finalLimit = negative ? negNext : next_acc;
    wire digitState = state == ascii_number_parser_pkg::ST_DIGITS;
    wire reachLimit = limitOn && (digitCount + 5'h01 >= effLimit);
    wire finishTerm = digitState && byteValid && !isDigit;
    wire finishLimit = digitState && byteValid && isDigit && reachLimit;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ascii_number_parser_pkg::ST_IDLE: begin
                next_state = state;
            end
            ascii_number_parser_pkg::ST_SEQ: begin
                if (seqMatched) begin
                    next_state = ascii_number_parser_pkg::ST_SCAN;
                end
            end
            ascii_number_parser_pkg::ST_SCAN: begin
                // Unwanted bytes are dropped and scanning goes on
                if (byteValid) begin
                    if (cfgSigned && isMinus) begin
                        next_state = ascii_number_parser_pkg::ST_MINUS;
                    end else if (needPrefix && prefixOk) begin
                        next_state = ascii_number_parser_pkg::ST_PREFIX;
                    end else if (!cfgPrefixed && isDigit) begin
                        next_state = ascii_number_parser_pkg::ST_DIGITS;
                    end
                end
            end
            ascii_number_parser_pkg::ST_MINUS: begin
                if (byteValid) begin
                    if (isMinus) begin
                        next_state = state;
                    end else if (needPrefix && prefixOk) begin
                        next_state = ascii_number_parser_pkg::ST_PREFIX;
                    end else if (!cfgPrefixed && isDigit) begin
                        next_state = ascii_number_parser_pkg::ST_DIGITS;
                    end else begin
                        next_state = ascii_number_parser_pkg::ST_SCAN;
                    end
                end
            end
            ascii_number_parser_pkg::ST_PREFIX: begin
                if (byteValid) begin
                    if (isDigit) begin
                        next_state = ascii_number_parser_pkg::ST_DIGITS;
                    end else if (needPrefix && prefixOk) begin
                        next_state = state;
                    end else begin
                        next_state = ascii_number_parser_pkg::ST_SCAN;
                    end
                end
            end
            ascii_number_parser_pkg::ST_DIGITS: begin
                if (finishTerm || finishLimit) begin
                    next_state = ascii_number_parser_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = ascii_number_parser_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    wire enterDigits = byteValid && isDigit && !digitState
        && next_state == ascii_number_parser_pkg::ST_DIGITS;
    wire seqNeeded = seqLength != 3'h0;
    // A one-digit limit ends on the digit that opens the number
    wire firstNeg = state == ascii_number_parser_pkg::ST_MINUS
        || (state == ascii_number_parser_pkg::ST_PREFIX && negative);
    wire [15:0] firstVal = firstNeg ? 16'h0000 - firstAcc : firstAcc;
    wire finishFirst = enterDigits && limitOn && effLimit == 5'h01;
    wire finishAny = finishTerm || finishLimit || finishFirst;
    wire [15:0] storeVal = finishFirst ? firstVal
        : finishLimit ? finalLimit : finalTerm;
    wire [15:0] storeMasked = cfgByte
        ? {8'h00, storeVal[7:0]} : storeVal;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ascii_number_parser_pkg::ST_IDLE;
            cfgRadix <= ascii_number_parser_pkg::RADIX_TEN;
            cfgSigned <= 1'b0;
            cfgPrefixed <= 1'b0;
            cfgLimit <= 5'h00;
            cfgByte <= 1'b0;
            cfgSeqLength <= 3'h0;
        end else if (clkEn) begin
            if (start) begin
                state <= seqNeeded ? ascii_number_parser_pkg::ST_SEQ
                    : ascii_number_parser_pkg::ST_SCAN;
                cfgRadix <= radixSel;
                cfgSigned <= signedFormat;
                cfgPrefixed <= prefixedFormat;
                cfgLimit <= digitLimit;
                cfgByte <= byteWide;
                // Longer patterns are cut to the six-byte store
                cfgSeqLength <= (seqLength > 3'(SEQ_MAX))
                    ? 3'(SEQ_MAX) : seqLength;
            end else begin
                state <= finishFirst ? ascii_number_parser_pkg::ST_IDLE
                    : next_state;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 16'h0000;
            digitCount <= 5'h00;
            negative <= 1'b0;
            activeRadix <= ascii_number_parser_pkg::RADIX_TEN;
        end else if (clkEn) begin
            if (start) begin
                negative <= 1'b0;
            end else if (enterDigits) begin
                acc <= firstAcc;
                digitCount <= 5'h01;
                negative <= firstNeg;
            end else if (digitState && byteValid && isDigit) begin
                acc <= next_acc;
                digitCount <= digitCount + 5'h01;
            end else if (byteValid
                    && state == ascii_number_parser_pkg::ST_PREFIX) begin
                negative <= negative && prefixOk;
            end else if (byteValid
                    && state == ascii_number_parser_pkg::ST_SCAN) begin
                negative <= cfgSigned && isMinus && needPrefix;
                if (prefixOk) begin
                    negative <= 1'b0;
                end
            end else if (byteValid
                    && state == ascii_number_parser_pkg::ST_MINUS
                    && needPrefix) begin
                negative <= prefixOk;
            end
            // Radix tracks the prefix seen, or the plain radix
            if (byteValid && prefixOk && needPrefix && !digitState) begin
                activeRadix <= prefixRadix;
            end else if (byteValid && !digitState
                    && state != ascii_number_parser_pkg::ST_PREFIX) begin
                activeRadix <= plainRadix;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            result <= 16'h0000;
        end else if (clkEn) begin
            done <= finishAny;
            if (finishAny) begin
                result <= storeMasked;
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
            end
        end
    end
    // The parser never stalls: one byte is used per strobe
    // and no ready signal exists toward the byte receiver.
endmodule : ascii_number_parser

// ### ascii_number_parser_assertions.sv
// Port-level assertion checker for the ASCII number parser
`timescale 1ns/10ps
module ascii_number_parser_checker #(
    parameter int SEQ_MAX = ascii_number_parser_pkg::SEQ_MAX
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic start,
    input wire logic byteWide,
    input wire logic [2:0] seqLength,
    input wire logic byteValid,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] result
);
    // ************************************************************
    // Configuration copy and byte counter
    // ************************************************************
    logic wideCfg;
    logic [2:0] seqCfg;
    logic [15:0] byteCount;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wideCfg <= 1'b0;
            seqCfg <= 3'h0;
            byteCount <= 16'h0000;
        end else if (start && clkEn) begin
            wideCfg <= byteWide;
            seqCfg <= seqLength;
            byteCount <= 16'h0000;
        end else if (busy && byteValid && clkEn) begin
            byteCount <= byteCount + 16'h0001;
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    a_done_pulse: assert property (done && clkEn |=> !done)
        else $error("done held longer than one cycle");
    a_done_idle: assert property (done |-> !busy)
        else $error("busy still high with done");
    a_start_busy: assert property (start && clkEn |=> busy)
        else $error("busy not raised after start");
    a_result_hold: assert property (!done |-> $stable(result))
        else $error("result changed without done");
    a_byte_dest: assert property (done && wideCfg |-> result[15:8] == 8'h00)
        else $error("upper byte not zero for byte destination");
    a_done_busy: assert property (done |-> $past(busy))
        else $error("done without a parse in progress");
    a_done_byte: assert property (done |-> $past(byteValid))
        else $error("done not caused by a received byte");
    a_seq_wait: assert property (done |-> byteCount > {13'h0, seqCfg})
        else $error("number finished before the pattern arrived");
endmodule : ascii_number_parser_checker

bind ascii_number_parser ascii_number_parser_checker #(.SEQ_MAX(SEQ_MAX)) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .start(start),
    .byteWide(byteWide),
    .seqLength(seqLength),
    .byteValid(byteValid),
    .busy(busy),
    .done(done),
    .result(result)
);

// ### byte_source_model.sv
// Byte receiver model that feeds received text one strobe per byte
`timescale 1ns/10ps
module byte_source_model (
    input wire logic clk_sys,
    output logic byteValid,
    output logic [7:0] byteData
);
    initial begin
        byteValid = 1'b0;
        byteData = 8'h00;
    end
    // Gap of zero gives back to back bytes; idle data keeps toggling
    task automatic sendText(input string text, input int gap);
        for (int i = 0; i < text.len(); i++) begin
            @(posedge clk_sys);
            #2;
            byteValid = 1'b1;
            byteData = text[i];
            repeat (gap) begin
                @(posedge clk_sys);
                #2;
                byteValid = 1'b0;
                byteData = ~byteData;
            end
        end
        @(posedge clk_sys);
        #2;
        byteValid = 1'b0;
        byteData = ~byteData;
    endtask : sendText
endmodule : byte_source_model

// ### tb_ascii_number_parser.sv
// Self-checking testbench for the ASCII number parser
`timescale 1ns/10ps
module tb_ascii_number_parser;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk_sys, rst_n, clkEn, start, signedFormat, prefixedFormat;
    logic byteWide, byteValid, busy, done, doneSeen;
    logic [1:0] radixSel;
    logic [4:0] digitLimit;
    logic [2:0] seqLength;
    logic [47:0] seqPattern;
    logic [7:0] byteData;
    logic [15:0] result, resultSeen;
    int mismatches = 0;
    int samplesChecked = 0;
    ascii_number_parser u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .clkEn(clkEn), .start(start), .radixSel(radixSel),
        .signedFormat(signedFormat), .prefixedFormat(prefixedFormat),
        .digitLimit(digitLimit), .byteWide(byteWide),
        .seqLength(seqLength), .seqPattern(seqPattern),
        .byteValid(byteValid), .byteData(byteData), .busy(busy),
        .done(done), .result(result));
    byte_source_model u_src (.clk_sys(clk_sys), .byteValid(byteValid),
        .byteData(byteData));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Done is a single-cycle pulse, so it is caught here
    always @(posedge clk_sys) begin
        if (done === 1'b1) begin
            doneSeen <= 1'b1;
            resultSeen <= result;
        end
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (mismatches == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic setCfg(input logic [1:0] r, input logic s, input logic p,
        input logic [4:0] l, input logic w);
        @(posedge clk_sys);
        #2;
        radixSel = r;
        signedFormat = s;
        prefixedFormat = p;
        digitLimit = l;
        byteWide = w;
        start = 1'b1;
        doneSeen = 1'b0;
        @(posedge clk_sys);
        #2;
        start = 1'b0;
    endtask : setCfg
    task automatic expectDone(input logic [15:0] exp);
        int n;
        for (n = 0; n < 40 && doneSeen !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (n == 40) begin
            mismatches++;
            $display("ERROR %0t: no completion", $time);
            end_of_test();
        end else begin
            check(resultSeen, exp);
        end
    endtask : expectDone
    task automatic parse(input string text, input logic [15:0] exp);
        u_src.sendText(text, 0);
        expectDone(exp);
    endtask : parse
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic scnDecimal;
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("ABCD123EFGH", 16'd123);
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b0);
        u_src.sendText("123", 0);
        repeat (8) @(posedge clk_sys);
        #2;
        check({15'h0, doneSeen}, 16'h0000);
        check({15'h0, busy}, 16'h0001);
        parse(" ", 16'd123);
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("70000 ", 16'h1170);
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b1);
        parse("300 ", 16'h002c);
    endtask : scnDecimal
    task automatic scnRadix;
        setCfg(2'b00, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("2101x", 16'h0005);
        setCfg(2'b10, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("GaB;", 16'h00ab);
        setCfg(2'b01, 1'b0, 1'b0, 5'h02, 1'b0);
        parse("12", 16'd12);
        setCfg(2'b10, 1'b0, 1'b0, 5'h04, 1'b0);
        parse("beef", 16'hbeef);
        setCfg(2'b00, 1'b0, 1'b0, 5'h10, 1'b0);
        parse("1111111111111111", 16'hffff);
    endtask : scnRadix
    task automatic scnSigned;
        setCfg(2'b01, 1'b1, 1'b0, 5'h00, 1'b0);
        parse("- -25 ", 16'hffe7);
        setCfg(2'b10, 1'b1, 1'b0, 5'h00, 1'b0);
        parse("-A0;", 16'hff60);
    endtask : scnSigned
    task automatic scnPrefix;
        setCfg(2'b10, 1'b0, 1'b1, 5'h00, 1'b0);
        parse("12 $ $1f ", 16'h001f);
        setCfg(2'b00, 1'b1, 1'b1, 5'h00, 1'b0);
        parse("-%101 ", 16'hfffb);
        setCfg(2'b00, 1'b1, 1'b1, 5'h00, 1'b0);
        parse("10 %-101 %11 ", 16'h0003);
    endtask : scnPrefix
    task automatic scnGeneric;
        setCfg(2'b11, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("42 ", 16'd42);
        setCfg(2'b11, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("$ff ", 16'h00ff);
        setCfg(2'b11, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("%11 ", 16'h0003);
        setCfg(2'b11, 1'b1, 1'b0, 5'h00, 1'b0);
        parse("-32768 ", 16'h8000);
    endtask : scnGeneric
    task automatic scnSequence;
        seqLength = 3'h3;
        seqPattern = {24'h000000, "ZYX"};
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b0);
        u_src.sendText("xYZ7 XYZ9 ", 2);
        expectDone(16'd9);
        seqLength = 3'h6;
        seqPattern = "EMASES";
        setCfg(2'b01, 1'b0, 1'b0, 5'h00, 1'b0);
        parse("SESAM4SESAME5 ", 16'd5);
        seqLength = 3'h0;
    endtask : scnSequence
    // A byte sent while the clock enable is low is lost
    task automatic scnFreeze;
        setCfg(2'b01, 1'b0, 1'b0, 5'h01, 1'b0);
        clkEn = 1'b0;
        u_src.sendText("9", 0);
        clkEn = 1'b1;
        parse("78", 16'd7);
    endtask : scnFreeze
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        start = 1'b0;
        radixSel = 2'b01;
        signedFormat = 1'b0;
        prefixedFormat = 1'b0;
        digitLimit = 5'h00;
        byteWide = 1'b0;
        seqLength = 3'h0;
        seqPattern = 48'h000000000000;
        doneSeen = 1'b0;
        resultSeen = 16'h0000;
        repeat (16) @(posedge clk_sys);
        #2;
        rst_n = 1'b1;
        scnDecimal();
        scnRadix();
        scnSigned();
        scnPrefix();
        scnGeneric();
        scnSequence();
        scnFreeze();
        end_of_test();
    end
endmodule : tb_ascii_number_parser
